// File: temp_sensor_regs.sv
// two-wire target with scratch, identity, limits, averaging and alert
`timescale 1ns/100ps
module temp_sensor_regs #(
    parameter int CONV_CYCLES_P = temp_sensor_pkg::CONV_CYCLES,
    parameter int RESET_CYCLES_P = temp_sensor_pkg::SOFT_RESET_CYCLES,
    parameter logic [6:0] TARGET_BASE = 7'h48,
    // arbitrary identity values
    parameter logic [3:0] PART_REVISION = 4'h0,
    parameter logic [11:0] PART_CODE = 12'h5A3
)(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic targetAddressSelectPin,
    output logic alertOut,
    output logic alertOe,
    input wire logic [temp_sensor_pkg::WORD_W-1:0] rawSample,
    input wire logic rawValid,
    output logic convStart,
    output logic nvmProgram,
    output logic [temp_sensor_pkg::WORD_W-1:0] nvmData,
    input wire logic nvmBusy
);
    import temp_sensor_pkg::*;

    localparam int CT_W = $clog2(CONV_CYCLES_P + 1);
    localparam int RT_W = $clog2(RESET_CYCLES_P + 1);

    logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3, pinS1, pinS2;
    logic sclRise, sclFall, busStart, busStop;
    bus_state_t state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [1:0] byteIdx, next_byteIdx;
    logic [7:0] shiftReg, next_shiftReg, pointer, next_pointer;
    logic [7:0] dataMsb, next_dataMsb;
    logic [15:0] txWord, next_txWord, readWord;
    logic txLow, next_txLow, isRead, next_isRead;
    logic isGenCall, next_isGenCall, next_sdaOe, commit;
    logic [15:0] configReg, next_configReg, highLimit, next_highLimit;
    logic [15:0] lowLimit, next_lowLimit, scratchWord, next_scratchWord;
    logic [15:0] resultReg, next_resultReg, next_nvmData, writeWord;
    logic unlockBit, next_unlockBit, next_nvmProgram, next_convStart;
    logic next_alertOe, newResult;
    logic signed [ACC_W-1:0] acc, next_acc, sum;
    logic [6:0] sampleCnt, next_sampleCnt;
    logic [CT_W-1:0] convTimer, next_convTimer;
    logic [RT_W-1:0] resetCnt, next_resetCnt;
    logic everHigh, everLow, diffSda, diffScl;
    logic next_everHigh, next_everLow, next_diffSda, next_diffScl;
    logic [1:0] addrSel;
    logic [6:0] myAddr;

    function automatic logic [2:0] avgShift(input logic [1:0] field);
        unique case (field)
            AVG_1: avgShift = 3'h0;
            AVG_8: avgShift = 3'h3;
            AVG_32: avgShift = 3'h5;
            AVG_64: avgShift = 3'h6;
        endcase
    endfunction

    function automatic logic [15:0] regRead(input logic [7:0] ptr);
        unique case (ptr)
            REG_RESULT: regRead = resultReg;
            REG_CONFIG: regRead = configReg;
            REG_HIGH: regRead = highLimit;
            REG_LOW: regRead = lowLimit;
            REG_UNLOCK: regRead = {unlockBit, nvmBusy, 14'h0000};
            REG_SCRATCH: regRead = scratchWord; // RULE1
            REG_IDENT: regRead = {PART_REVISION, PART_CODE}; // RULE5 RULE6
            default: regRead = ZERO_WORD;
        endcase
    endfunction

    // pins are asynchronous to clk_sys; edges come from the second stage
    always_ff @(posedge clk_sys)
    begin
        sclS1 <= sclIn;
        sclS2 <= sclS1;
        sclS3 <= sclS2;
        sdaS1 <= sdaIn;
        sdaS2 <= sdaS1;
        sdaS3 <= sdaS2;
        pinS1 <= targetAddressSelectPin;
        pinS2 <= pinS1;
    end

    assign sclRise = sclS2 && !sclS3;
    assign sclFall = !sclS2 && sclS3;
    assign busStart = sclS2 && sdaS3 && !sdaS2;
    assign busStop = sclS2 && !sdaS3 && sdaS2;
    assign writeWord = {dataMsb, shiftReg};
    // a continuous assign would miss register updates behind the function
    always_comb
    begin
        readWord = regRead(pointer);
    end

    // a pin strapped to a bus line only reveals itself once traffic runs
    always_comb
    begin
        if (!everHigh)
            addrSel = 2'h0;
        else if (!everLow)
            addrSel = 2'h1;
        else if (!diffSda && diffScl)
            addrSel = 2'h2;
        else
            addrSel = 2'h3;
        myAddr = TARGET_BASE + {5'h00, addrSel}; // RULE8
    end

    always_comb
    begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_byteIdx = byteIdx;
        next_shiftReg = shiftReg;
        next_pointer = pointer;
        next_dataMsb = dataMsb;
        next_txWord = txWord;
        next_txLow = txLow;
        next_isRead = isRead;
        next_isGenCall = isGenCall;
        next_sdaOe = sdaOe;
        next_configReg = configReg;
        next_highLimit = highLimit;
        next_lowLimit = lowLimit;
        next_scratchWord = scratchWord;
        next_resultReg = resultReg;
        next_unlockBit = unlockBit;
        next_nvmProgram = 1'b0;
        next_nvmData = nvmData;
        next_convStart = 1'b0;
        next_alertOe = alertOe;
        next_acc = acc;
        next_sampleCnt = sampleCnt;
        next_convTimer = convTimer;
        next_resetCnt = resetCnt;
        commit = 1'b0;
        newResult = 1'b0;
        sum = acc + {{(ACC_W-WORD_W){rawSample[15]}}, rawSample};
        next_everHigh = everHigh || pinS2; // RULE8
        next_everLow = everLow || !pinS2;
        next_diffSda = diffSda || (pinS2 != sdaS2);
        next_diffScl = diffScl || (pinS2 != sclS2);

        // target only: data is pulled low or released, never driven high
        unique case (state) // RULE7
            ST_IDLE:
            begin
                next_sdaOe = 1'b0;
            end
            ST_RECV:
            begin
                if (sclRise && bitCnt != BYTE_BITS)
                begin
                    next_shiftReg = {shiftReg[6:0], sdaS2};
                    next_bitCnt = bitCnt + 4'h1;
                end
                else if (sclFall && bitCnt == BYTE_BITS)
                begin
                    next_bitCnt = 4'h0;
                    next_state = ST_ACK;
                    next_sdaOe = 1'b1;
                    next_byteIdx = (byteIdx == 2'h3) ? 2'h2 : byteIdx + 2'h1;
                    unique case (byteIdx)
                        2'h0:
                        begin
                            next_isRead = shiftReg[0];
                            next_isGenCall = shiftReg == GENCALL_ADDR;
                            if (shiftReg[7:1] != myAddr &&
                                shiftReg != GENCALL_ADDR)
                            begin
                                next_state = ST_IDLE;
                                next_sdaOe = 1'b0;
                            end
                        end
                        2'h1:
                        begin
                            if (!isGenCall)
                                next_pointer = shiftReg; // RULE14
                            else if (shiftReg == GENCALL_RESET)
                                next_resetCnt = RT_W'(RESET_CYCLES_P); // RULE12
                        end
                        2'h2:
                        begin
                            next_dataMsb = shiftReg; // RULE14
                        end
                        2'h3:
                        begin
                            commit = !isGenCall; // RULE14
                        end
                    endcase
                end
            end
            ST_ACK:
            begin
                if (sclFall && isRead)
                begin
                    next_txWord = readWord; // RULE14
                    next_sdaOe = !readWord[15];
                    next_bitCnt = 4'h1;
                    next_txLow = 1'b0;
                    next_state = ST_SEND;
                end
                else if (sclFall)
                begin
                    next_sdaOe = 1'b0;
                    next_state = ST_RECV;
                end
            end
            ST_SEND:
            begin
                if (sclFall && bitCnt == BYTE_BITS)
                begin
                    next_sdaOe = 1'b0;
                    next_state = ST_MACK;
                end
                else if (sclFall)
                begin
                    next_sdaOe = !txWord[14];
                    next_txWord = {txWord[14:0], 1'b0};
                    next_bitCnt = bitCnt + 4'h1;
                end
            end
            ST_MACK:
            begin
                if (sclRise && sdaS2)
                    next_state = ST_IDLE;
                else if (sclFall && !txLow)
                begin
                    next_sdaOe = !txWord[14];
                    next_txWord = {txWord[14:0], 1'b0};
                    next_bitCnt = 4'h1;
                    next_txLow = 1'b1;
                    next_state = ST_SEND;
                end
                else if (sclFall)
                begin
                    next_txWord = readWord;
                    next_sdaOe = !readWord[15];
                    next_bitCnt = 4'h1;
                    next_txLow = 1'b0;
                    next_state = ST_SEND;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        if (busStart)
        begin
            next_state = ST_RECV;
            next_bitCnt = 4'h0;
            next_byteIdx = 2'h0;
            next_sdaOe = 1'b0;
        end
        else if (busStop)
        begin
            next_state = ST_IDLE;
            next_sdaOe = 1'b0;
        end

        // identity and result words accept no writes
        if (commit) // RULE4
        begin
            unique case (pointer)
                REG_CONFIG: next_configReg = writeWord;
                REG_HIGH: next_highLimit = writeWord;
                REG_LOW: next_lowLimit = writeWord;
                REG_UNLOCK: next_unlockBit = writeWord[UNLOCK_BIT];
                REG_SCRATCH:
                begin
                    next_scratchWord = writeWord; // RULE1
                    if (unlockBit) // RULE2
                    begin
                        next_nvmProgram = 1'b1;
                        next_nvmData = writeWord;
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (resetCnt != {RT_W{1'b0}})
        begin
            // held in reset; pacing restarts from zero when it ends
            next_resetCnt = resetCnt - RT_W'(1); // RULE12
            next_convTimer = {CT_W{1'b0}};
            next_acc = {ACC_W{1'b0}};
            next_sampleCnt = 7'h00;
            next_configReg = CONFIG_RESET;
            next_highLimit = HIGH_RESET;
            next_lowLimit = LOW_RESET;
            next_unlockBit = 1'b0;
            next_alertOe = 1'b0;
        end
        else
        begin
            if (convTimer == {CT_W{1'b0}})
            begin
                next_convStart = 1'b1; // RULE11
                next_convTimer = CT_W'(CONV_CYCLES_P - 1);
            end
            else
                next_convTimer = convTimer - CT_W'(1);
            if (rawValid)
            begin
                if (sampleCnt + 7'h01 ==
                    7'h01 << avgShift(configReg[AVG_LSB+:2])) // RULE10
                begin
                    next_resultReg = WORD_W'(sum >>>
                        avgShift(configReg[AVG_LSB+:2]));
                    next_acc = {ACC_W{1'b0}};
                    next_sampleCnt = 7'h00;
                    newResult = 1'b1;
                end
                else
                begin
                    next_acc = sum;
                    next_sampleCnt = sampleCnt + 7'h01;
                end
            end
            // new count starts empty; a stale count could overrun the target
            if (commit && pointer == REG_CONFIG) // RULE10
            begin
                next_acc = {ACC_W{1'b0}};
                next_sampleCnt = 7'h00;
            end
            if (newResult) // RULE9
                next_alertOe = $signed(next_resultReg) > $signed(highLimit)
                    || $signed(next_resultReg) < $signed(lowLimit);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            byteIdx <= 2'h0;
            shiftReg <= 8'h00;
            pointer <= REG_RESULT;
            dataMsb <= 8'h00;
            txWord <= ZERO_WORD;
            txLow <= 1'b0;
            isRead <= 1'b0;
            isGenCall <= 1'b0;
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            alertOut <= 1'b0;
            configReg <= CONFIG_RESET;
            highLimit <= HIGH_RESET;
            lowLimit <= LOW_RESET;
            scratchWord <= ZERO_WORD;
            resultReg <= ZERO_WORD;
            unlockBit <= 1'b0;
            nvmProgram <= 1'b0;
            nvmData <= ZERO_WORD;
            convStart <= 1'b0;
            alertOe <= 1'b0;
            acc <= {ACC_W{1'b0}};
            sampleCnt <= 7'h00;
            convTimer <= {CT_W{1'b0}};
            resetCnt <= {RT_W{1'b0}};
            everHigh <= 1'b0;
            everLow <= 1'b0;
            diffSda <= 1'b0;
            diffScl <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            byteIdx <= next_byteIdx;
            shiftReg <= next_shiftReg;
            pointer <= next_pointer;
            dataMsb <= next_dataMsb;
            txWord <= next_txWord;
            txLow <= next_txLow;
            isRead <= next_isRead;
            isGenCall <= next_isGenCall;
            sdaOe <= next_sdaOe;
            sdaOut <= 1'b0;
            alertOut <= 1'b0;
            configReg <= next_configReg;
            highLimit <= next_highLimit;
            lowLimit <= next_lowLimit;
            scratchWord <= next_scratchWord;
            resultReg <= next_resultReg;
            unlockBit <= next_unlockBit;
            nvmProgram <= next_nvmProgram;
            nvmData <= next_nvmData;
            convStart <= next_convStart;
            alertOe <= next_alertOe;
            acc <= next_acc;
            sampleCnt <= next_sampleCnt;
            convTimer <= next_convTimer;
            resetCnt <= next_resetCnt;
            everHigh <= next_everHigh;
            everLow <= next_everLow;
            diffSda <= next_diffSda;
            diffScl <= next_diffScl;
        end
    end

    AST_SCRATCH_WRITE: assert property (@(posedge clk_sys) // RULE1
        disable iff (reset) commit && pointer == REG_SCRATCH
        && resetCnt == {RT_W{1'b0}} |=> scratchWord == $past(writeWord))
        else $error("scratch word did not take the written value");
    AST_LOCKED_NO_PROGRAM: assert property (@(posedge clk_sys) // RULE2
        disable iff (reset)
        commit && pointer == REG_SCRATCH && !unlockBit |=> !nvmProgram)
        else $error("nonvolatile program while locked");
    AST_UNLOCKED_PROGRAM: assert property (@(posedge clk_sys) // RULE2
        disable iff (reset) commit && pointer == REG_SCRATCH && unlockBit
        |=> nvmProgram && nvmData == $past(writeWord))
        else $error("unlocked scratch write did not program");
    AST_IDENT_LOAD: assert property (@(posedge clk_sys) // RULE4
        disable iff (reset)
        state == ST_ACK && sclFall && isRead && pointer == REG_IDENT
        |=> txWord == {PART_REVISION, PART_CODE})
        else $error("identification word read back wrong");
    AST_TARGET_ONLY: assert property (@(posedge clk_sys) // RULE7
        disable iff (reset)
        !sdaOut && !alertOut && (state != ST_IDLE || !sdaOe))
        else $error("data line driven outside a transfer");
    AST_ALERT_ON_LIMIT: assert property (@(posedge clk_sys) // RULE9
        disable iff (reset)
        newResult && $signed(next_resultReg) > $signed(highLimit)
        |=> alertOe)
        else $error("alert missing above high limit");
    AST_AVG_ONE: assert property (@(posedge clk_sys) // RULE10
        disable iff (reset) rawValid && resetCnt == {RT_W{1'b0}}
        && configReg[AVG_LSB+:2] == AVG_1 |=> resultReg == $past(rawSample))
        else $error("single-sample result differs from sample");
    AST_PACING: assert property (@(posedge clk_sys) // RULE11
        disable iff (reset) convStart |-> $past(convTimer) == {CT_W{1'b0}}
        ##1 !convStart[*2])
        else $error("conversion start out of pace");
    AST_SOFT_RESET: assert property (@(posedge clk_sys) // RULE12
        disable iff (reset)
        resetCnt != {RT_W{1'b0}} |=> !convStart && configReg == CONFIG_RESET)
        else $error("activity during general-call reset");
endmodule

// File: temp_sensor_pkg.sv
// constants and types shared by the temperature sensor register block
// Operation
// (RULE1) Register 08h is a 16-bit read/write scratch word holding user data.
// (RULE2) Scratch writes hit only the logic register while unlock is clear, and program the nonvolatile copy while set.
// (RULE3) The host should never erase or rewrite the first scratch word, which holds factory identity data.
// (RULE4) Register 0Fh is a read-only identification word that host writes cannot change.
// (RULE5) Identification bits 15:12 report the silicon revision.
// (RULE6) Identification bits 11:0 report a fixed twelve-bit part code.
// (RULE7) The device is only a bus target: the host drives the clock, data is two-way, alert is an output.
// (RULE8) The address-select pin picks one of four target addresses: ground, supply, data or clock.
// (RULE9) Alert is signalled when the result crosses the limits in registers 02h and 03h.
// (RULE10) Results average 1, 8, 32 or 64 consecutive conversions.
// (RULE11) An eight-conversion average completes in 125 ms.
// (RULE12) A general-call reset resets the device for about 1.5 ms, then sampling restarts.
// (RULE13) After a synchronising reset in 16 s cycles the host should read each result within 16 s.
// (RULE14) Every access moves a 16-bit word, high byte first, after a pointer byte.
package temp_sensor_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int ACC_W = 22;
    localparam logic [7:0] REG_RESULT = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h01;
    localparam logic [7:0] REG_HIGH = 8'h02;
    localparam logic [7:0] REG_LOW = 8'h03;
    localparam logic [7:0] REG_UNLOCK = 8'h04;
    localparam logic [7:0] REG_SCRATCH = 8'h08;
    localparam logic [7:0] REG_IDENT = 8'h0F;
    localparam int UNLOCK_BIT = 15;
    localparam int AVG_LSB = 5;
    localparam logic [1:0] AVG_1 = 2'h0;
    localparam logic [1:0] AVG_8 = 2'h1;
    localparam logic [1:0] AVG_32 = 2'h2;
    localparam logic [1:0] AVG_64 = 2'h3;
    localparam logic [15:0] CONFIG_RESET = 16'h0020;
    localparam logic [15:0] HIGH_RESET = 16'h6000;
    localparam logic [15:0] LOW_RESET = 16'h8000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0] GENCALL_ADDR = 8'h00;
    localparam logic [7:0] GENCALL_RESET = 8'h06;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int AVG8_TIME_US = 125_000;
    localparam int AVG8_SAMPLES = 8;
    localparam int CONV_CYCLES =
        (CLK_HZ / 1_000_000) * AVG8_TIME_US / AVG8_SAMPLES;
    localparam int SOFT_RESET_NS = 1_500_000;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK = 3'b010,
        ST_SEND = 3'b011,
        ST_MACK = 3'b100
    } bus_state_t;
endpackage

// File: two_wire_host.sv
// host controller model for the two-wire register bus
`timescale 1ns/100ps
module two_wire_host (
    input wire logic clk_sys,
    input wire logic sdaLine,
    output logic sclLine,
    output logic sdaLow
);
    logic r;
    initial
    begin
        sclLine = 1'b1;
        sdaLow = 1'b0;
    end
    // four clocks a quarter bit, well past the pin synchronisers
    task automatic tick;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic bitx(input logic b, output logic s);
        sdaLow = ~b;
        tick;
        sclLine = 1'b1;
        tick;
        s = sdaLine;
        tick;
        sclLine = 1'b0;
        tick;
    endtask
    task automatic start;
        sdaLow = 1'b0;
        tick;
        sclLine = 1'b1;
        tick;
        sdaLow = 1'b1;
        tick;
        sclLine = 1'b0;
        tick;
    endtask
    // clock stays high while idle
    task automatic stop;
        sdaLow = 1'b1;
        tick;
        sclLine = 1'b1;
        tick;
        sdaLow = 1'b0;
        tick;
    endtask
    task automatic wrByte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rdByte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, r);
            d = {d[6:0], r};
        end
        bitx(last, r);
    endtask
endmodule

// File: temp_sensor_regs_tb.sv
// self-checking bench for the sensor register block
`timescale 1ns/100ps
`define CHK(nm, ex, sn) \
begin \
    testsRun++; \
    if ((sn) !== (ex)) \
    begin \
        fails++; \
        $display("ERROR %s expected %h seen %h", nm, ex, sn); \
    end \
end
module temp_sensor_regs_tb;
    import temp_sensor_pkg::*;
    localparam int CONV_P = 20;
    localparam int RST_P = 10;
    localparam logic [6:0] BASE = 7'h48;
    // arbitrary identity values
    localparam logic [3:0] REV = 4'h3;
    localparam logic [11:0] CODE = 12'h2C6;
    localparam logic [15:0] IDENT = {REV, CODE};
    typedef struct {logic [7:0] p; logic [15:0] w; logic wr;
        logic [15:0] e;} row_t;
    row_t rows[9] = '{'{REG_SCRATCH, 16'hA55A, 1'b1, 16'hA55A},
        '{REG_SCRATCH, 16'hFFFF, 1'b1, 16'hFFFF},
        '{REG_SCRATCH, 16'h0000, 1'b1, 16'h0000},
        '{REG_IDENT, 16'hFFFF, 1'b1, IDENT}, '{REG_IDENT, 16'h0000, 1'b0, IDENT},
        '{8'h0A, 16'h1234, 1'b1, ZERO_WORD},
        '{REG_HIGH, 16'h0100, 1'b1, 16'h0100},
        '{REG_LOW, 16'hFF00, 1'b1, 16'hFF00},
        '{REG_CONFIG, 16'h0000, 1'b1, 16'h0000}};
    int cnt[4] = '{1, 8, 32, 64};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sclLine, sdaLow, sdaLine, sdaOut, sdaOe, alertOut, alertOe;
    logic pinSel = 1'b0;
    logic [6:0] addr = BASE;
    logic rawValid = 1'b0;
    logic nvmBusy = 1'b0;
    logic convStart, nvmProgram, ack;
    logic [15:0] rawSample = 16'h0000;
    logic [15:0] nvmData, nvmLast, got;
    int testsRun = 0;
    int fails = 0;
    int nvmCount = 0;
    int n;
    always #12.5 clk_sys = ~clk_sys;
    // open drain with pull-up: low if either side pulls
    assign sdaLine = ~(sdaLow | sdaOe);
    always @(posedge clk_sys)
        if (nvmProgram === 1'b1)
        begin
            nvmCount <= nvmCount + 1;
            nvmLast <= nvmData;
        end
    temp_sensor_regs #(.CONV_CYCLES_P(CONV_P), .RESET_CYCLES_P(RST_P),
        .TARGET_BASE(BASE), .PART_REVISION(REV), .PART_CODE(CODE))
    temp_sensor_regs_inst (.clk_sys(clk_sys), .reset(reset),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .targetAddressSelectPin(pinSel), .alertOut(alertOut),
        .alertOe(alertOe), .rawSample(rawSample), .rawValid(rawValid),
        .convStart(convStart), .nvmProgram(nvmProgram),
        .nvmData(nvmData), .nvmBusy(nvmBusy));
    two_wire_host two_wire_host_inst (.clk_sys(clk_sys),
        .sdaLine(sdaLine), .sclLine(sclLine), .sdaLow(sdaLow));
    task automatic wrReg(input logic [7:0] p, input logic [15:0] d);
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte({addr, 1'b0}, ack);
        `CHK("address ack", 1'b1, ack)
        two_wire_host_inst.wrByte(p, ack);
        two_wire_host_inst.wrByte(d[15:8], ack);
        two_wire_host_inst.wrByte(d[7:0], ack);
        two_wire_host_inst.stop;
    endtask
    task automatic rdReg(input logic [7:0] p, output logic [15:0] d);
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte({addr, 1'b0}, ack);
        two_wire_host_inst.wrByte(p, ack);
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte({addr, 1'b1}, ack);
        two_wire_host_inst.rdByte(1'b0, d[15:8]);
        two_wire_host_inst.rdByte(1'b1, d[7:0]);
        two_wire_host_inst.stop;
    endtask
    task automatic sample(input logic [15:0] v);
        @(posedge clk_sys);
        #1 rawSample = v;
        rawValid = 1'b1;
        @(posedge clk_sys);
        #1 rawValid = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic wrapUp;
        $display("counts: %0d compared, %0d wrong", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        wrapUp;
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        rdReg(REG_CONFIG, got);
        `CHK("config reset", CONFIG_RESET, got)
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wrReg(rows[i].p, rows[i].w);
            rdReg(rows[i].p, got);
            `CHK("row read", rows[i].e, got)
        end
        `CHK("never driven high", 1'b0, sdaOut | alertOut)
        $display("test rows done");
        sample(16'h0200);
        `CHK("alert high", 1'b1, alertOe)
        rdReg(REG_RESULT, got);
        `CHK("single result", 16'h0200, got)
        sample(16'hFE00);
        `CHK("alert low", 1'b1, alertOe)
        sample(16'h0000);
        `CHK("alert clear", 1'b0, alertOe)
        $display("test alert done");
        wrReg(REG_UNLOCK, 16'h8000);
        wrReg(REG_SCRATCH, 16'hBEEF);
        `CHK("nvm count", 1, nvmCount)
        `CHK("nvm data", 16'hBEEF, nvmLast)
        wrReg(REG_UNLOCK, 16'h0000);
        wrReg(REG_SCRATCH, 16'h1357);
        `CHK("locked count", 1, nvmCount)
        $display("test unlock done");
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte({7'h4A, 1'b0}, ack);
        two_wire_host_inst.stop;
        `CHK("foreign address", 1'b0, ack)
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte(GENCALL_ADDR, ack);
        two_wire_host_inst.wrByte(GENCALL_RESET, ack);
        two_wire_host_inst.stop;
        n = 0;
        while (convStart !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        while (convStart !== 1'b1 && n < 100);
        `CHK("conversion spacing", CONV_P, n)
        rdReg(REG_CONFIG, got);
        `CHK("config restored", CONFIG_RESET, got)
        rdReg(REG_SCRATCH, got);
        `CHK("scratch kept", 16'h1357, got)
        // ramp samples: a wrong count shifts the mean
        for (int m = 1; m < 4; m++)
        begin
            wrReg(REG_CONFIG, 16'(m << AVG_LSB));
            for (int k = 0; k < cnt[m]; k++)
                sample(16'(4 * k));
            rdReg(REG_RESULT, got);
            `CHK("averaged", 16'(2 * (cnt[m] - 1)), got)
        end
        $display("test general call done");
        @(posedge clk_sys);
        #1 reset = 1'b1;
        pinSel = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        // strap now at supply: ground address must be refused
        two_wire_host_inst.start;
        two_wire_host_inst.wrByte({BASE, 1'b0}, ack);
        two_wire_host_inst.stop;
        `CHK("ground address refused", 1'b0, ack)
        addr = BASE + 7'h01;
        rdReg(REG_SCRATCH, got);
        `CHK("scratch reset", ZERO_WORD, got)
        rdReg(REG_HIGH, got);
        `CHK("high reset", HIGH_RESET, got)
        $display("test reset done");
        wrapUp;
    end
endmodule
